// [hdl/spsc_map.svh]
/*
  register offsets, field positions, reset values and timing counts of the
  supply protection and state control block.
  assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
`ifndef SPSC_MAP_SVH
`define SPSC_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SPSC_OFS_CMD    8'h00
`define SPSC_OFS_ARG    8'h04
`define SPSC_OFS_STAT   8'h08
`define SPSC_OFS_OVP    8'h0C
`define SPSC_OFS_FAULT  8'h10
`define SPSC_OFS_ERR    8'h14
`define SPSC_OFS_VOLTAGE_SETPOINT_CMD   8'h18
`define SPSC_OFS_CURRENT_SETPOINT_CMD   8'h1C

// ----------------------------------------
// fault register bit positions
// ----------------------------------------
`define SPSC_FB_CV      0
`define SPSC_FB_CC      1
`define SPSC_FB_OR      2
`define SPSC_FB_OV      3
`define SPSC_FB_FOLDBACK_SELECT_CMD    4
`define SPSC_FAULT_W    5

// ----------------------------------------
// error codes, reset values and range limits
// ----------------------------------------
`define SPSC_ERR_NONE   4'h0
`define SPSC_ERR_SYNTAX 4'h4
`define SPSC_ERR_RANGE  4'h5
`define SPSC_ERR_CEIL   4'h6
`define SPSC_ERR_FLOOR  4'h7
`define SPSC_CEIL_RST   16'hFFFF
`define SPSC_SLOT_MAX   16'h000F
`define SPSC_MASK_MAX   16'h001F

// ----------------------------------------
// mask delay timing
// ----------------------------------------
`define SPSC_CLK_PERIOD_NS 20
`define SPSC_DLY_STEP_NS   1000000
`define SPSC_DLY_DEF_MS    16'd500
`define SPSC_DLY_MAX_MS    16'd31999

`endif

// [hdl/spsc_pkg.sv]
/*
  types of the supply protection and state control block.
  opcode and foldback encodings are set here, not taken from spsc_map.svh.
*/
package spsc_pkg;

  // ----------------------------------------
  // command opcodes, written to the command register
  // ----------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE = 4'b0000,
    CMD_VOLTAGE_SETPOINT_CMD = 4'b0001,
    CMD_CURRENT_SETPOINT_CMD = 4'b0010,
    CMD_VOLTAGE_CEILING_CMD = 4'b0011,
    CMD_CURRENT_CEILING_CMD = 4'b0100,
    CMD_FOLDBACK_SELECT_CMD = 4'b0101,
    CMD_MASK = 4'b0110,
    CMD_HOLD = 4'b0111,
    CMD_TRG  = 4'b1000,
    CMD_STO  = 4'b1001,
    CMD_RCL  = 4'b1010,
    CMD_CLR  = 4'b1011,
    CMD_OUT  = 4'b1100,
    CMD_RST  = 4'b1101,
    CMD_DLY  = 4'b1110,
    CMD_OVP  = 4'b1111
  } spsc_cmd_e;

  typedef enum logic [1:0] {
    FOLDBACK_SELECT_CMD_OFF = 2'b00,
    FOLDBACK_SELECT_CMD_CC  = 2'b01,
    FOLDBACK_SELECT_CMD_CV  = 2'b10
  } spsc_foldback_select_cmd_e;

endpackage

// [hdl/spsc_mask_dly.sv]
/*
  mask delay timer: busy for a number of millisecond steps after start.
  assumes start is a one-cycle pulse on aclk; a zero delay never goes busy.
*/
`timescale 1ns/1ns
module spsc_mask_dly #(
  parameter int unsigned MS_CYCLES = 50000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic [15:0] dly_ms,
  output logic             busy
);
  localparam int unsigned PW = $clog2(MS_CYCLES);

  logic [PW-1:0] pre_q;
  logic [15:0]   ms_q;
  logic          busy_q;
  wire           step = busy_q && (pre_q == PW'(MS_CYCLES - 1));

  // ----------------------------------------
  // prescaler and millisecond count
  // ----------------------------------------
  // a restart reloads the full delay, so overlapping events extend the mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q  <= '0;
      ms_q   <= 16'h0000;
      busy_q <= 1'b0;
    end else if (start) begin
      pre_q  <= '0;
      ms_q   <= dly_ms;
      busy_q <= (dly_ms != 16'h0000);
    end else if (step) begin
      pre_q  <= '0;
      ms_q   <= ms_q - 16'h0001;
      busy_q <= (ms_q != 16'h0001);
    end else if (busy_q) begin
      pre_q <= pre_q + PW'(1);
    end
  end

  assign busy = busy_q;
endmodule

// [hdl/spsc_top.sv]
/*
  supply protection and state control: command interpreter behind an
  AXI4-Lite slave, with protection latches, dual-rank settings and 16 slots.
  assumes cc_mode, cv_mode, overrange, ov_trip, meas_v, meas_i and
  group_exec_trigger come from logic on aclk; inhibit_input_pin is a pin.
*/
`timescale 1ns/1ns
`include "spsc_map.svh"

module spsc_top #(
  parameter int unsigned DW        = 16,
  parameter int unsigned AW        = 8,
  parameter int unsigned MS_CYCLES = `SPSC_DLY_STEP_NS / `SPSC_CLK_PERIOD_NS
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          group_exec_trigger,
  input  wire logic          constant_current_mode,
  input  wire logic          constant_voltage_mode,
  input  wire logic          overrange,
  input  wire logic          ov_trip,
  input  wire logic [DW-1:0] meas_v,
  input  wire logic [DW-1:0] meas_i,
  input  wire logic          inhibit_input_pin,
  output logic               fault_indicator_pin,
  output logic               output_enable,
  output logic [DW-1:0]      voltage_setpoint_cmd_out,
  output logic [DW-1:0]      current_setpoint_cmd_out
);

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic          awready_q, wready_q, bvalid_q, aw_got_q, w_got_q;
  logic          arready_q, rvalid_q;
  logic [1:0]    bresp_q, rresp_q;
  logic [31:0]   rdata_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;

  wire aw_hs   = s_axi_awvalid && awready_q;
  wire w_hs    = s_axi_wvalid && wready_q;
  wire ar_hs   = s_axi_arvalid && arready_q;
  wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire wa_cmd  = (awaddr_q == `SPSC_OFS_CMD);
  wire wa_arg  = (awaddr_q == `SPSC_OFS_ARG);
  wire ra_ok   = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `SPSC_OFS_CURRENT_SETPOINT_CMD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'b00;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        aw_got_q  <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wa_cmd || wa_arg) ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // command and argument
  // ----------------------------------------
  logic [DW-1:0] arg_q;
  logic [3:0]    op_q;
  logic          go_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg_q <= '0;
      op_q  <= 4'h0;
      go_q  <= 1'b0;
    end else begin
      go_q <= wr_fire && wa_cmd && wstrb_q[0];
      if (wr_fire && wa_cmd && wstrb_q[0]) op_q <= wdata_q[3:0];
      if (wr_fire && wa_arg && wstrb_q[0]) arg_q[7:0] <= wdata_q[7:0];
      if (wr_fire && wa_arg && wstrb_q[1]) arg_q[DW-1:8] <= wdata_q[DW-1:8];
    end
  end

  // ----------------------------------------
  // settings: first rank (_b) and active rank (_a)
  // ----------------------------------------
  logic [DW-1:0] voltage_setpoint_cmd_b_q, current_setpoint_cmd_b_q, voltage_setpoint_cmd_a_q, current_setpoint_cmd_a_q, voltage_ceiling_cmd_q, current_ceiling_cmd_q, ovp_q;
  logic [1:0]    foldback_select_cmd_b_q, foldback_select_cmd_a_q;
  logic [4:0]    mask_b_q, mask_a_q;
  logic [15:0]   dly_q;
  logic          hold_q, out_on_q, foldback_select_cmd_lat_q, ov_lat_q;
  logic [3:0]    err_q;
  logic [4:0]    fault_q;

  // snapshot slots: data only, kept across reset and initialise
  logic [DW-1:0] slot_v_q [16];
  logic [DW-1:0] slot_i_q [16];
  logic [1:0]    slot_f_q [16];
  logic [4:0]    slot_m_q [16];

  wire [3:0] sel    = arg_q[3:0];
  wire is_voltage_setpoint_cmd      = (op_q == spsc_pkg::CMD_VOLTAGE_SETPOINT_CMD);
  wire is_current_setpoint_cmd      = (op_q == spsc_pkg::CMD_CURRENT_SETPOINT_CMD);
  wire is_voltage_ceiling_cmd      = (op_q == spsc_pkg::CMD_VOLTAGE_CEILING_CMD);
  wire is_current_ceiling_cmd      = (op_q == spsc_pkg::CMD_CURRENT_CEILING_CMD);
  wire is_foldback_select_cmd      = (op_q == spsc_pkg::CMD_FOLDBACK_SELECT_CMD);
  wire is_mask      = (op_q == spsc_pkg::CMD_MASK);
  wire is_hold      = (op_q == spsc_pkg::CMD_HOLD);
  wire is_trg       = (op_q == spsc_pkg::CMD_TRG);
  wire is_sto       = (op_q == spsc_pkg::CMD_STO);
  wire is_rcl       = (op_q == spsc_pkg::CMD_RCL);
  wire is_clr       = (op_q == spsc_pkg::CMD_CLR);
  wire is_out       = (op_q == spsc_pkg::CMD_OUT);
  wire is_rst       = (op_q == spsc_pkg::CMD_RST);
  wire is_dly       = (op_q == spsc_pkg::CMD_DLY);
  wire is_ovp       = (op_q == spsc_pkg::CMD_OVP);

  // error screening before anything executes
  wire e_syn   = (op_q == spsc_pkg::CMD_NONE);
  wire e_rng   = (is_foldback_select_cmd && arg_q > DW'(2)) || ((is_sto || is_rcl) && arg_q > `SPSC_SLOT_MAX)
              || (is_mask && arg_q > `SPSC_MASK_MAX) || (is_dly && arg_q > `SPSC_DLY_MAX_MS)
              || ((is_hold || is_out) && arg_q > DW'(1));
  wire e_ceil  = (is_voltage_setpoint_cmd && arg_q > voltage_ceiling_cmd_q) || (is_current_setpoint_cmd && arg_q > current_ceiling_cmd_q);
  wire e_floor = (is_voltage_ceiling_cmd && meas_v > arg_q) || (is_current_ceiling_cmd && meas_i > arg_q);
  wire [3:0] ecode = e_syn   ? `SPSC_ERR_SYNTAX :
                     e_rng   ? `SPSC_ERR_RANGE  :
                     e_ceil  ? `SPSC_ERR_CEIL   :
                     e_floor ? `SPSC_ERR_FLOOR  : `SPSC_ERR_NONE;
  wire ok      = go_q && (ecode == `SPSC_ERR_NONE);
  wire trigger_cmd     = (ok && is_trg) || group_exec_trigger;
  wire recall_state_cmd     = ok && is_rcl;
  wire rst     = ok && is_rst;
  wire clr     = ok && is_clr;
  wire wr_live = ok && !hold_q;
  wire dly_go  = trigger_cmd || recall_state_cmd || rst || (ok && is_out && arg_q[0])
              || (wr_live && (is_voltage_setpoint_cmd || is_current_setpoint_cmd));
  wire [DW-1:0] rcl_v = slot_v_q[sel];

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      voltage_setpoint_cmd_b_q <= '0;
      current_setpoint_cmd_b_q <= '0;
      voltage_setpoint_cmd_a_q <= '0;
      current_setpoint_cmd_a_q <= '0;
      voltage_ceiling_cmd_q   <= `SPSC_CEIL_RST;
      current_ceiling_cmd_q   <= `SPSC_CEIL_RST;
      foldback_select_cmd_b_q <= spsc_pkg::FOLDBACK_SELECT_CMD_OFF;
      foldback_select_cmd_a_q <= spsc_pkg::FOLDBACK_SELECT_CMD_OFF;
      mask_b_q <= 5'h00;
      mask_a_q <= 5'h00;
      dly_q    <= `SPSC_DLY_DEF_MS;
      hold_q   <= 1'b0;
      out_on_q <= 1'b1;
      ovp_q    <= `SPSC_CEIL_RST;
    end else if (trigger_cmd) begin
      voltage_setpoint_cmd_a_q <= voltage_setpoint_cmd_b_q;
      current_setpoint_cmd_a_q <= current_setpoint_cmd_b_q;
      foldback_select_cmd_a_q <= foldback_select_cmd_b_q;
      mask_a_q <= mask_b_q;
    end else if (recall_state_cmd) begin
      voltage_setpoint_cmd_b_q <= slot_v_q[sel];
      current_setpoint_cmd_b_q <= slot_i_q[sel];
      foldback_select_cmd_b_q <= slot_f_q[sel];
      mask_b_q <= slot_m_q[sel];
      voltage_setpoint_cmd_a_q <= slot_v_q[sel];
      current_setpoint_cmd_a_q <= slot_i_q[sel];
      foldback_select_cmd_a_q <= slot_f_q[sel];
      mask_a_q <= slot_m_q[sel];
    end else if (ok) begin
      if (is_voltage_setpoint_cmd) voltage_setpoint_cmd_b_q <= arg_q;
      if (is_current_setpoint_cmd) current_setpoint_cmd_b_q <= arg_q;
      if (is_foldback_select_cmd) foldback_select_cmd_b_q <= arg_q[1:0];
      if (is_mask) mask_b_q <= arg_q[4:0];
      if (wr_live && is_voltage_setpoint_cmd) voltage_setpoint_cmd_a_q <= arg_q;
      if (wr_live && is_current_setpoint_cmd) current_setpoint_cmd_a_q <= arg_q;
      if (wr_live && is_foldback_select_cmd) foldback_select_cmd_a_q <= arg_q[1:0];
      if (wr_live && is_mask) mask_a_q <= arg_q[4:0];
      if (is_voltage_ceiling_cmd) voltage_ceiling_cmd_q <= arg_q;
      if (is_current_ceiling_cmd) current_ceiling_cmd_q <= arg_q;
      if (is_hold) hold_q <= arg_q[0];
      if (is_out)  out_on_q <= arg_q[0];
      if (is_dly)  dly_q <= arg_q;
      if (is_ovp)  ovp_q <= arg_q;
    end
  end

  // output on/off stays outside the snapshot
  always_ff @(posedge aclk) begin
    if (ok && is_sto) begin
      slot_v_q[sel] <= voltage_setpoint_cmd_a_q;
      slot_i_q[sel] <= current_setpoint_cmd_a_q;
      slot_f_q[sel] <= foldback_select_cmd_a_q;
      slot_m_q[sel] <= mask_a_q;
    end
  end

  // ----------------------------------------
  // mask delay and protection
  // ----------------------------------------
  logic masking;

  spsc_mask_dly #(
    .MS_CYCLES (MS_CYCLES)
  ) u_dly (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (dly_go),
    .dly_ms  (dly_q),
    .busy    (masking)
  );

  wire cc_eff   = constant_current_mode && !masking;
  wire cv_eff   = constant_voltage_mode && !masking;
  wire or_eff   = overrange && !masking;
  wire foldback_select_cmd_set = (foldback_select_cmd_a_q == spsc_pkg::FOLDBACK_SELECT_CMD_CC && cc_eff)
               || (foldback_select_cmd_a_q == spsc_pkg::FOLDBACK_SELECT_CMD_CV && cv_eff);
  wire [4:0] cond = {foldback_select_cmd_lat_q, ov_lat_q, or_eff, cc_eff, cv_eff};

  // inhibit pin: three stages, a change counts once stages two and three agree
  logic inh_s1_q, inh_s2_q, inh_s3_q, inh_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inh_s1_q <= 1'b0;
      inh_s2_q <= 1'b0;
      inh_s3_q <= 1'b0;
      inh_q    <= 1'b0;
    end else begin
      inh_s1_q <= inhibit_input_pin;
      inh_s2_q <= inh_s1_q;
      inh_s3_q <= inh_s2_q;
      if (inh_s2_q == inh_s3_q) inh_q <= inh_s3_q;
    end
  end

  wire rd_fault = ar_hs && (s_axi_araddr == `SPSC_OFS_FAULT);
  wire rd_err   = ar_hs && (s_axi_araddr == `SPSC_OFS_ERR);

  // latches set over clear: a trip present during reset stays tripped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      foldback_select_cmd_lat_q          <= 1'b0;
      ov_lat_q            <= 1'b0;
      err_q               <= `SPSC_ERR_NONE;
      output_enable       <= 1'b0;
      fault_indicator_pin <= 1'b0;
    end else begin
      foldback_select_cmd_lat_q <= foldback_select_cmd_set || (foldback_select_cmd_lat_q && !rst);
      ov_lat_q   <= ov_trip || (ov_lat_q && !rst);
      if (go_q && ecode != `SPSC_ERR_NONE) err_q <= ecode;
      else if (rd_err) err_q <= `SPSC_ERR_NONE;
      output_enable <= out_on_q && !inh_q && !foldback_select_cmd_lat_q && !ov_lat_q;
      fault_indicator_pin <= |(fault_q & mask_a_q);
    end
  end

  // sticky fault bits, cleared by reading the fault register
  for (genvar b = 0; b < `SPSC_FAULT_W; b++) begin : g_fault
    always_ff @(posedge aclk) begin
      if (!aresetn) fault_q[b] <= 1'b0;
      else fault_q[b] <= cond[b] || (fault_q[b] && !rd_fault);
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire [31:0] stat_w = {24'h0000_00, foldback_select_cmd_a_q, masking, inh_q, ov_lat_q, foldback_select_cmd_lat_q,
                        hold_q, output_enable};
  wire [31:0] rd_mux =
    (s_axi_araddr == `SPSC_OFS_ARG)   ? {{(32-DW){1'b0}}, arg_q}    :
    (s_axi_araddr == `SPSC_OFS_STAT)  ? stat_w                      :
    (s_axi_araddr == `SPSC_OFS_OVP)   ? {{(32-DW){1'b0}}, ovp_q}    :
    (s_axi_araddr == `SPSC_OFS_FAULT) ? {27'h000_0000, fault_q}     :
    (s_axi_araddr == `SPSC_OFS_ERR)   ? {28'h000_0000, err_q}       :
    (s_axi_araddr == `SPSC_OFS_VOLTAGE_SETPOINT_CMD)  ? {{(32-DW){1'b0}}, voltage_setpoint_cmd_a_q} :
    (s_axi_araddr == `SPSC_OFS_CURRENT_SETPOINT_CMD)  ? {{(32-DW){1'b0}}, current_setpoint_cmd_a_q} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'b00;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= ra_ok ? 2'b00 : 2'b10;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign voltage_setpoint_cmd_out      = voltage_setpoint_cmd_a_q;
  assign current_setpoint_cmd_out      = current_setpoint_cmd_a_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fault_pin_on: assert property (|(fault_q & mask_a_q) |=> fault_indicator_pin)
    else $error("fault pin not raised for unmasked fault");
  a_inhibit_kills: assert property (inh_q |=> !output_enable)
    else $error("output on while inhibited");
  a_foldback_select_cmd_trip_off: assert property (foldback_select_cmd_set |=> foldback_select_cmd_lat_q ##1 !output_enable)
    else $error("foldback did not shut output");
  a_rst_clears: assert property (rst && !ov_trip && !foldback_select_cmd_set |=> !ov_lat_q && !foldback_select_cmd_lat_q)
    else $error("protection reset left latch set");
  a_latch_holds: assert property (ov_lat_q && !rst |=> ov_lat_q)
    else $error("overvoltage latch dropped without reset");
  a_hold_active: assert property (hold_q && ok && is_voltage_setpoint_cmd && !trigger_cmd && !clr
    |=> voltage_setpoint_cmd_a_q == $past(voltage_setpoint_cmd_a_q))
    else $error("active voltage changed in hold mode");
  a_trigger_copy: assert property (group_exec_trigger && !clr
    |=> voltage_setpoint_cmd_a_q == $past(voltage_setpoint_cmd_b_q) && mask_a_q == $past(mask_b_q))
    else $error("trigger did not load active rank");
  a_ceiling_reject: assert property (go_q && is_voltage_setpoint_cmd && arg_q > voltage_ceiling_cmd_q && !group_exec_trigger
    |=> err_q == `SPSC_ERR_CEIL && voltage_setpoint_cmd_b_q == $past(voltage_setpoint_cmd_b_q))
    else $error("setpoint above ceiling not rejected");
  a_floor_reject: assert property (go_q && is_voltage_ceiling_cmd && meas_v > arg_q
    |=> err_q == `SPSC_ERR_FLOOR && voltage_ceiling_cmd_q == $past(voltage_ceiling_cmd_q))
    else $error("ceiling below operating point accepted");
  a_mask_start: assert property (dly_go && dly_q != 16'h0000 |=> masking [*2])
    else $error("mask delay did not start");
  a_recall_load: assert property (recall_state_cmd |=> voltage_setpoint_cmd_a_q == $past(rcl_v))
    else $error("recall did not restore slot");

  c_trigger: cover property (hold_q && group_exec_trigger);
  c_foldback_select_cmd_trip: cover property (foldback_select_cmd_set ##1 foldback_select_cmd_lat_q ##[1:20] rst);
  c_sto_rcl: cover property ((ok && is_sto) ##[1:50] recall_state_cmd);
  c_ceil_err: cover property (go_q && e_ceil);

endmodule

// [sim/spsc_plant.sv]
/*
  plant model: turns active setpoints into readings and regulation modes.
  assumes the bench selects constant current through force_cc.
*/
`timescale 1ns/1ns
module spsc_plant (
  input  wire logic        en,
  input  wire logic        force_cc,
  input  wire logic [15:0] voltage_setpoint_cmd,
  input  wire logic [15:0] current_setpoint_cmd,
  output logic             cc,
  output logic             cv,
  output logic [15:0]      meas_v,
  output logic [15:0]      meas_i
);
  // ----------------------------------------
  // regulation
  // ----------------------------------------
  // output off: nothing regulates, readings fall to zero
  assign cc     = en & force_cc;
  assign cv     = en & ~force_cc;
  assign meas_v = en ? voltage_setpoint_cmd : 16'h0000;
  assign meas_i = en ? current_setpoint_cmd : 16'h0000;
endmodule

// [sim/tb_top.sv]
/*
  self-checking bench: AXI4-Lite master tasks and one task per scenario.
  assumes spsc_top with MS_CYCLES 5 and the plant model on its far side.
*/
`timescale 1ns/1ns
module tb_top;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_arvalid = 0, group_exec_trigger = 0, ov_trip = 0;
  logic        inhibit_input_pin = 0, force_cc = 0, s_axi_awready, s_axi_wready;
  logic        overrange = 0;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, fault_indicator_pin;
  logic        output_enable, constant_current_mode, constant_voltage_mode;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] meas_v, meas_i, voltage_setpoint_cmd_out, current_setpoint_cmd_out;
  int          mismatches = 0, tests_run = 0;
  always #10 aclk = ~aclk;
  // ready lines stay high: every response is taken the edge it shows
  spsc_top #(.MS_CYCLES(5)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1),
    .group_exec_trigger, .constant_current_mode, .constant_voltage_mode,
    .overrange, .ov_trip, .meas_v, .meas_i, .inhibit_input_pin,
    .fault_indicator_pin, .output_enable, .voltage_setpoint_cmd_out, .current_setpoint_cmd_out);
  spsc_plant i_plant (.en(output_enable), .force_cc, .voltage_setpoint_cmd(voltage_setpoint_cmd_out), .current_setpoint_cmd(current_setpoint_cmd_out),
    .cc(constant_current_mode), .cv(constant_voltage_mode), .meas_v, .meas_i);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 40) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n = 0;
    logic aw = 0, w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w && s_axi_bvalid === 1'b1)) begin
      step(n);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    chk("bresp", 32'(s_axi_bresp), (a > 8'h04) ? 32'h0000_0002 : 32'h0000_0000);
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, exp);
    int   n = 0;
    logic ar = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    while (!(ar && s_axi_rvalid === 1'b1)) begin
      step(n);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 0;
      end
    end
    chk(what, s_axi_rdata & m, exp);
    chk("rresp", 32'(s_axi_rresp), (a > 8'h1C) ? 32'h0000_0002 : 32'h0000_0000);
  endtask
  // argument first, then opcode; two edges let the effect land
  task automatic cmd(input logic [3:0] op, input logic [15:0] arg);
    wr(8'h04, {16'h0000, arg});
    wr(8'h00, {28'h000_0000, op});
    repeat (2) @(posedge aclk);
  endtask
  task automatic pins(input logic fe, pe, input int cyc);
    repeat (cyc) @(posedge aclk);
    chk("out_en", 32'(output_enable), 32'(fe));
    chk("flt_pin", 32'(fault_indicator_pin), 32'(pe));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_limits();
    rchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    cmd(4'h0, 16'h0000);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0004);
    cmd(4'h5, 16'h0003);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0005);
    cmd(4'h3, 16'h0064);
    cmd(4'h1, 16'h0065);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0006);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0000);
    cmd(4'h1, 16'h0064);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0064);
    cmd(4'h3, 16'h0032);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0007);
    cmd(4'h1, 16'h0064);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("limits done");
  endtask
  task automatic t_hold();
    cmd(4'h7, 16'h0001);
    cmd(4'h1, 16'h0028);
    cmd(4'h2, 16'h0005);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0064);
    chk("current_setpoint_cmd", 32'(current_setpoint_cmd_out), 32'h0000_0000);
    group_exec_trigger <= 1;
    @(posedge aclk);
    group_exec_trigger <= 0;
    repeat (3) @(posedge aclk);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0028);
    chk("current_setpoint_cmd", 32'(current_setpoint_cmd_out), 32'h0000_0005);
    cmd(4'h4, 16'h0004);
    rchk("err", 8'h14, 32'hFFFF_FFFF, 32'h0000_0007);
    cmd(4'h1, 16'h001E);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0028);
    cmd(4'h8, 16'h0000);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_001E);
    cmd(4'h7, 16'h0000);
    $display("hold done");
  endtask
  task automatic t_protect();
    cmd(4'hE, 16'h0000);
    rchk("masking", 8'h08, 32'h0000_0020, 32'h0000_0020);
    overrange <= 1;
    @(posedge aclk);
    rchk("or_masked", 8'h10, 32'h0000_0004, 32'h0000_0000);
    overrange <= 0;
    // a zero delay only takes hold at the next restart, so switch output on again
    cmd(4'hC, 16'h0001);
    rchk("masking", 8'h08, 32'h0000_0020, 32'h0000_0000);
    overrange <= 1;
    @(posedge aclk);
    rchk("or_seen", 8'h10, 32'h0000_0004, 32'h0000_0004);
    overrange <= 0;
    cmd(4'h6, 16'h0002);
    cmd(4'h5, 16'h0001);
    pins(1, 0, 1);
    force_cc <= 1;
    pins(0, 1, 4);
    force_cc <= 0;
    pins(0, 1, 4);
    rchk("foldback_select_cmd_latch", 8'h08, 32'h0000_0004, 32'h0000_0004);
    cmd(4'hD, 16'h0000);
    chk("out_en", 32'(output_enable), 32'h0000_0001);
    cmd(4'h5, 16'h0002);
    pins(0, 1, 2);
    cmd(4'h5, 16'h0000);
    cmd(4'hD, 16'h0000);
    chk("out_en", 32'(output_enable), 32'h0000_0001);
    cmd(4'hF, 16'h007B);
    rchk("ovp", 8'h0C, 32'h0000_FFFF, 32'h0000_007B);
    ov_trip <= 1;
    @(posedge aclk);
    ov_trip <= 0;
    pins(0, 1, 3);
    cmd(4'hD, 16'h0000);
    chk("out_en", 32'(output_enable), 32'h0000_0001);
    inhibit_input_pin <= 1;
    repeat (8) @(posedge aclk);
    chk("out_en", 32'(output_enable), 32'h0000_0000);
    inhibit_input_pin <= 0;
    $display("protect done");
  endtask
  task automatic t_slots();
    cmd(4'h9, 16'h0003);
    cmd(4'h1, 16'h0014);
    cmd(4'h9, 16'h000F);
    cmd(4'hC, 16'h0000);
    cmd(4'h9, 16'h0001);
    cmd(4'hC, 16'h0001);
    cmd(4'hA, 16'h0001);
    chk("out_en", 32'(output_enable), 32'h0000_0001);
    cmd(4'hB, 16'h0000);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0000);
    cmd(4'hA, 16'h000F);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_0014);
    cmd(4'hA, 16'h0003);
    chk("voltage_setpoint_cmd", 32'(voltage_setpoint_cmd_out), 32'h0000_001E);
    $display("slots done");
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_limits();
    t_hold();
    t_protect();
    t_slots();
    tally_and_finish();
  end
endmodule
